// ---- design/cqef_top.sv ----
// Lower half of the interrupt flag register of the CAN FD controller,
// with its enable, line select and line enable registers.
// Assumes event inputs come from the Tx handler, Rx handler and FIFO logic
// on the same clock; level inputs are held by that logic for as long as true.
`timescale 1ns/10ps

module cqef_top
	import cqef_pkg::*;
#(
	parameter int ADDR_W = CQEF_ADDR_W,
	parameter int DATA_W = CQEF_DATA_W
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Register port
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wr_data,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	output logic [DATA_W-1:0] o_rd_data,
	// Tx event FIFO
	input wire logic i_txevent_lost,
	input wire logic i_txevent_write_try,
	input wire logic i_txevent_size_zero,
	input wire logic i_txevent_full,
	input wire logic i_txevent_level,
	input wire logic i_txevent_new,
	// Tx FIFO and transmission status
	input wire logic i_tx_queue_empty,
	input wire logic i_tx_cancel_done,
	input wire logic i_tx_done,
	input wire logic i_priority_msg,
	// Rx FIFO 1
	input wire logic i_rxq1_lost,
	input wire logic i_rxq1_write_try,
	input wire logic i_rxq1_size_zero,
	input wire logic i_rxq1_full,
	input wire logic i_rxq1_level,
	input wire logic i_rxq1_new,
	// Rx FIFO 0
	input wire logic i_rxq0_lost,
	input wire logic i_rxq0_write_try,
	input wire logic i_rxq0_size_zero,
	input wire logic i_rxq0_full,
	input wire logic i_rxq0_level,
	input wire logic i_rxq0_new,
	// Interrupt lines and flag view
	output logic o_irq_line_first,
	output logic o_irq_line_second,
	output logic [CQEF_FLAG_W-1:0] o_flags
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [CQEF_FLAG_W-1:0] flags;
	logic [CQEF_FLAG_W-1:0] flag_set;
	logic [CQEF_FLAG_W-1:0] flag_clr;
	logic [CQEF_FLAG_W-1:0] cond_now;
	logic [CQEF_FLAG_W-1:0] cond_q;
	logic [CQEF_FLAG_W-1:0] cond_rise;
	logic [CQEF_FLAG_W-1:0] enable_q;
	logic [CQEF_FLAG_W-1:0] enable_d;
	logic [CQEF_FLAG_W-1:0] line_sel_q;
	logic [CQEF_FLAG_W-1:0] line_sel_d;
	logic [CQEF_LINE_W-1:0] line_en_q;
	logic [CQEF_LINE_W-1:0] line_en_d;
	logic [DATA_W-1:0] rd_data_q;
	logic [DATA_W-1:0] rd_data_d;
	logic irq_first_q;
	logic irq_first_d;
	logic irq_second_q;
	logic irq_second_d;
	logic hit_flags;
	logic hit_enable;
	logic hit_line_sel;
	logic hit_line_en;
	logic wr_flags;
	logic wr_enable;
	logic wr_line_sel;
	logic wr_line_en;
	logic txevent_lost_evt;
	logic rxq1_lost_evt;
	logic rxq0_lost_evt;
	logic [CQEF_FLAG_W-1:0] armed;
	logic [CQEF_FLAG_W-1:0] to_first;
	logic [CQEF_FLAG_W-1:0] to_second;

	// ****************************************************************
	// Address decode
	// ****************************************************************

	// Only the low sixteen address bits carry the map
	assign hit_flags = cqef_hit(i_addr[CQEF_ADDR_W-1:0], CQEF_OFS_FLAGS);
	assign hit_enable = cqef_hit(i_addr[CQEF_ADDR_W-1:0], CQEF_OFS_ENABLE);
	assign hit_line_sel = cqef_hit(i_addr[CQEF_ADDR_W-1:0], CQEF_OFS_LINE_SEL);
	assign hit_line_en = cqef_hit(i_addr[CQEF_ADDR_W-1:0], CQEF_OFS_LINE_EN);

	// Write strobes per register
	assign wr_flags = i_wr_en & hit_flags;
	assign wr_enable = i_wr_en & hit_enable;
	assign wr_line_sel = i_wr_en & hit_line_sel;
	assign wr_line_en = i_wr_en & hit_line_en;

	// ****************************************************************
	// Condition edge detection
	// ****************************************************************

	// Level conditions that set a flag when they first become true;
	// pulse-type positions stay low here and take the direct path below
	always_comb begin
		cond_now = '0;
		cond_now[CQEF_B_TXEVENT_FULL] = i_txevent_full;
		cond_now[CQEF_B_TXEVENT_LEVEL] = i_txevent_level;
		cond_now[CQEF_B_TX_QUEUE_EMPTY] = i_tx_queue_empty;
		cond_now[CQEF_B_RXQ1_FULL] = i_rxq1_full;
		cond_now[CQEF_B_RXQ1_LEVEL] = i_rxq1_level;
		cond_now[CQEF_B_RXQ0_FULL] = i_rxq0_full;
		cond_now[CQEF_B_RXQ0_LEVEL] = i_rxq0_level;
	end

	// History resets high: a queue empty at reset does not raise a flag
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cond_q <= CQEF_COND_RST;
		end else begin
			cond_q <= cond_now;
		end
	end

	// Rise seen in the very cycle the condition appears
	assign cond_rise = cond_now & ~cond_q;

	// ****************************************************************
	// Loss events
	// ****************************************************************

	// A write into a zero-size queue counts as a lost element
	assign txevent_lost_evt = i_txevent_lost | (i_txevent_write_try & i_txevent_size_zero);
	assign rxq1_lost_evt = i_rxq1_lost | (i_rxq1_write_try & i_rxq1_size_zero);
	assign rxq0_lost_evt = i_rxq0_lost | (i_rxq0_write_try & i_rxq0_size_zero);

	// ****************************************************************
	// Flag set vector
	// ****************************************************************

	// Tx event FIFO and transmit group
	assign flag_set[CQEF_B_TXEVENT_LOST] = txevent_lost_evt;
	assign flag_set[CQEF_B_TXEVENT_FULL] = cond_rise[CQEF_B_TXEVENT_FULL];
	assign flag_set[CQEF_B_TXEVENT_LEVEL] = cond_rise[CQEF_B_TXEVENT_LEVEL];
	assign flag_set[CQEF_B_TXEVENT_NEW] = i_txevent_new;
	assign flag_set[CQEF_B_TX_QUEUE_EMPTY] = cond_rise[CQEF_B_TX_QUEUE_EMPTY];
	assign flag_set[CQEF_B_TX_CANCEL_DONE] = i_tx_cancel_done;
	assign flag_set[CQEF_B_TX_DONE] = i_tx_done;
	assign flag_set[CQEF_B_PRIORITY_MSG] = i_priority_msg;

	// Rx FIFO 1 group
	assign flag_set[CQEF_B_RXQ1_LOST] = rxq1_lost_evt;
	assign flag_set[CQEF_B_RXQ1_FULL] = cond_rise[CQEF_B_RXQ1_FULL];
	assign flag_set[CQEF_B_RXQ1_LEVEL] = cond_rise[CQEF_B_RXQ1_LEVEL];
	assign flag_set[CQEF_B_RXQ1_NEW] = i_rxq1_new;

	// Rx FIFO 0 group
	assign flag_set[CQEF_B_RXQ0_LOST] = rxq0_lost_evt;
	assign flag_set[CQEF_B_RXQ0_FULL] = cond_rise[CQEF_B_RXQ0_FULL];
	assign flag_set[CQEF_B_RXQ0_LEVEL] = cond_rise[CQEF_B_RXQ0_LEVEL];
	assign flag_set[CQEF_B_RXQ0_NEW] = i_rxq0_new;

	// ****************************************************************
	// Flag storage
	// ****************************************************************

	// Write one to clear; writing zero leaves a flag alone
	assign flag_clr = wr_flags ? i_wr_data[CQEF_FLAG_W-1:0] : '0;

	// Sticky bank, set wins over a clear in the same cycle
	cqef_flag_bank #(
		.WIDTH(CQEF_FLAG_W),
		.RST_VAL(CQEF_FLAGS_RST)
	) u_flag_bank (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_set(flag_set),
		.i_clr(flag_clr),
		.o_flags(flags)
	);

	// ****************************************************************
	// Control registers
	// ****************************************************************

	// Next values of the software-owned registers
	assign enable_d = wr_enable ? i_wr_data[CQEF_FLAG_W-1:0] : enable_q;
	assign line_sel_d = wr_line_sel ? i_wr_data[CQEF_FLAG_W-1:0] : line_sel_q;
	assign line_en_d = wr_line_en ? i_wr_data[CQEF_LINE_W-1:0] : line_en_q;

	// Enable, line select and line enable storage
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			enable_q <= CQEF_ENABLE_RST;
			line_sel_q <= CQEF_LINE_SEL_RST;
			line_en_q <= CQEF_LINE_EN_RST;
		end else begin
			enable_q <= enable_d;
			line_sel_q <= line_sel_d;
			line_en_q <= line_en_d;
		end
	end

	// ****************************************************************
	// Interrupt routing
	// ****************************************************************

	// A disabled flag still records, it just stays off the lines
	assign armed = flags & enable_q;
	assign to_first = armed & ~line_sel_q;
	assign to_second = armed & line_sel_q;

	// Each line also needs its own master enable
	assign irq_first_d = (|to_first) & line_en_q[CQEF_B_LINE_FIRST];
	assign irq_second_d = (|to_second) & line_en_q[CQEF_B_LINE_SECOND];

	// Registered lines; one cycle behind the flags, glitch free
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			irq_first_q <= 1'b0;
			irq_second_q <= 1'b0;
		end else begin
			irq_first_q <= irq_first_d;
			irq_second_q <= irq_second_d;
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************

	// Upper bits read zero; unmapped addresses read zero
	always_comb begin
		rd_data_d = CQEF_RD_ZERO;
		if (hit_flags) begin
			rd_data_d[CQEF_FLAG_W-1:0] = flags;
		end else if (hit_enable) begin
			rd_data_d[CQEF_FLAG_W-1:0] = enable_q;
		end else if (hit_line_sel) begin
			rd_data_d[CQEF_FLAG_W-1:0] = line_sel_q;
		end else if (hit_line_en) begin
			rd_data_d[CQEF_LINE_W-1:0] = line_en_q;
		end
	end

	// Data stand only in the cycle after the read strobe
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rd_data_q <= CQEF_RD_ZERO;
		end else if (i_rd_en) begin
			rd_data_q <= rd_data_d;
		end else begin
			rd_data_q <= CQEF_RD_ZERO;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign o_rd_data = rd_data_q;
	assign o_irq_line_first = irq_first_q;
	assign o_irq_line_second = irq_second_q;
	assign o_flags = flags;

endmodule

// ---- inc/cqef_pkg.sv ----
// Constants for the queue event flag block of the CAN FD controller.
// Assumes one 10 MHz controller clock and a plain strobe register port.
package cqef_pkg;

	// ****************************************************************
	// Bus and register widths
	// ****************************************************************
	localparam int CQEF_ADDR_W = 16;
	localparam int CQEF_DATA_W = 32;
	localparam int CQEF_FLAG_W = 16;
	localparam int CQEF_LINE_W = 2;

	// ****************************************************************
	// Register offsets (byte addresses, one word each)
	// ****************************************************************
	localparam logic [15:0] CQEF_OFS_FLAGS = 16'h1050;
	localparam logic [15:0] CQEF_OFS_ENABLE = 16'h1054;
	localparam logic [15:0] CQEF_OFS_LINE_SEL = 16'h1058;
	localparam logic [15:0] CQEF_OFS_LINE_EN = 16'h105C;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [15:0] CQEF_FLAGS_RST = 16'h0000;
	localparam logic [15:0] CQEF_ENABLE_RST = 16'h0000;
	localparam logic [15:0] CQEF_LINE_SEL_RST = 16'h0000;
	localparam logic [1:0] CQEF_LINE_EN_RST = 2'h0;
	localparam logic [15:0] CQEF_COND_RST = 16'hFFFF;
	localparam logic [31:0] CQEF_RD_ZERO = 32'h00000000;

	// ****************************************************************
	// Flag bit positions
	// ****************************************************************
	localparam int CQEF_B_TXEVENT_LOST = 15;
	localparam int CQEF_B_TXEVENT_FULL = 14;
	localparam int CQEF_B_TXEVENT_LEVEL = 13;
	localparam int CQEF_B_TXEVENT_NEW = 12;
	localparam int CQEF_B_TX_QUEUE_EMPTY = 11;
	localparam int CQEF_B_TX_CANCEL_DONE = 10;
	localparam int CQEF_B_TX_DONE = 9;
	localparam int CQEF_B_PRIORITY_MSG = 8;
	localparam int CQEF_B_RXQ1_LOST = 7;
	localparam int CQEF_B_RXQ1_FULL = 6;
	localparam int CQEF_B_RXQ1_LEVEL = 5;
	localparam int CQEF_B_RXQ1_NEW = 4;
	localparam int CQEF_B_RXQ0_LOST = 3;
	localparam int CQEF_B_RXQ0_FULL = 2;
	localparam int CQEF_B_RXQ0_LEVEL = 1;
	localparam int CQEF_B_RXQ0_NEW = 0;

	// Line enable bits
	localparam int CQEF_B_LINE_FIRST = 0;
	localparam int CQEF_B_LINE_SECOND = 1;

	// Address match, used for every register decode
	function automatic logic cqef_hit(input logic [15:0] addr, input logic [15:0] ofs);
		cqef_hit = (addr == ofs);
	endfunction

endpackage

// ---- design/cqef_flag_bank.sv ----
// Bank of sticky flags: hardware sets, software clears.
// Assumes set and clear vectors are synchronous to the one clock.
`timescale 1ns/10ps

module cqef_flag_bank #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Set and clear requests
	input wire logic [WIDTH-1:0] i_set,
	input wire logic [WIDTH-1:0] i_clr,
	// Flag state
	output logic [WIDTH-1:0] o_flags
);

	logic [WIDTH-1:0] flags_q;
	logic [WIDTH-1:0] flags_d;

	// Set beats clear so an event in the clearing cycle survives
	assign flags_d = (flags_q & ~i_clr) | i_set;

	// Flags hold until cleared
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			flags_q <= RST_VAL;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign o_flags = flags_q;

endmodule

// ---- sim/cqef_props.sv ----
// Checker for the queue event flag block: port timing relations.
// Assumes it is bound to cqef_top and sees its ports by name.
`timescale 1ns/10ps

module cqef_props (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Register port
	input wire logic [15:0] i_addr,
	input wire logic [31:0] i_wr_data,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [31:0] o_rd_data,
	// Events
	input wire logic i_txevent_full,
	input wire logic i_tx_done,
	input wire logic i_rxq0_new,
	input wire logic i_rxq0_write_try,
	input wire logic i_rxq0_size_zero,
	// Interrupt lines and flags
	input wire logic o_irq_line_first,
	input wire logic o_irq_line_second,
	input wire logic [15:0] o_flags
);
	// ********
	// Flag and bus relations
	// ********
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// Software clear of bit 0 by write one
	wire clr0 = i_wr_en && i_addr == 16'h1050 && i_wr_data[0];

	new_sets_a: assert property (i_rxq0_new |=> o_flags[0])
		else $error("new message did not set its flag");
	done_sets_a: assert property (i_tx_done |=> o_flags[9])
		else $error("completed transmission did not set its flag");
	// Past reset guard: history holds ones through reset
	full_rise_a: assert property ($rose(i_txevent_full) && !$past(i_rst) |=> o_flags[14])
		else $error("full edge did not set its flag");
	zero_lost_a: assert property (i_rxq0_write_try && i_rxq0_size_zero |=> o_flags[3])
		else $error("zero size write did not set lost flag");
	flag_sticky_a: assert property (o_flags[0] && !clr0 |=> o_flags[0])
		else $error("flag dropped without a clear");
	flag_clear_a: assert property (clr0 && !i_rxq0_new |=> !o_flags[0])
		else $error("write one did not clear flag");
	set_wins_a: assert property (clr0 && i_rxq0_new |=> o_flags[0])
		else $error("event lost to a clear in the same cycle");
	irq_quiet_a: assert property (o_flags == 16'h0000 |=> !o_irq_line_first && !o_irq_line_second)
		else $error("interrupt line high with no flag set");
	rd_idle_a: assert property (!i_rd_en |=> o_rd_data == 32'h00000000)
		else $error("read data not zero outside a read");
	rd_flags_a: assert property (i_rd_en && i_addr == 16'h1050 |=> o_rd_data == {16'h0000, $past(o_flags)})
		else $error("flag read returned wrong value");
endmodule

bind cqef_top cqef_props props_u (.*);

// ---- sim/tb.sv ----
// Self-checking bench for the queue event flag block.
// Assumes cqef_top and its checker are compiled ahead of it.
`timescale 1ns/10ps

module tb
	import cqef_pkg::*;
;
	// ********
	// Stimulus and observed signals
	// ********
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_wr_en = 1'b0;
	logic i_rd_en = 1'b0;
	logic [15:0] i_addr = 16'h0000;
	logic [31:0] i_wr_data = 32'h00000000;
	logic [15:0] ev = 16'h0000; // One source per flag bit
	logic [2:0] wtry = 3'h0; // Order: rxq0, rxq1, tx event
	logic [2:0] szero = 3'h0;
	logic [31:0] o_rd_data;
	logic o_irq_line_first;
	logic o_irq_line_second;
	logic [15:0] o_flags;
	int n_mismatch = 0;
	int n_compared = 0;
	int lost_bit[3] = '{3, 7, 15};
	wire i_txevent_lost, i_txevent_full, i_txevent_level, i_txevent_new, i_tx_queue_empty, i_tx_cancel_done;
	wire i_tx_done, i_priority_msg, i_rxq1_lost, i_rxq1_full, i_rxq1_level, i_rxq1_new;
	wire i_rxq0_lost, i_rxq0_full, i_rxq0_level, i_rxq0_new;
	wire i_txevent_write_try, i_rxq1_write_try, i_rxq0_write_try;
	wire i_txevent_size_zero, i_rxq1_size_zero, i_rxq0_size_zero;
	// Level sources get a rising edge from a one cycle pulse
	assign {i_txevent_lost, i_txevent_full, i_txevent_level, i_txevent_new, i_tx_queue_empty, i_tx_cancel_done,
		i_tx_done, i_priority_msg, i_rxq1_lost, i_rxq1_full, i_rxq1_level, i_rxq1_new,
		i_rxq0_lost, i_rxq0_full, i_rxq0_level, i_rxq0_new} = ev;
	assign {i_txevent_write_try, i_rxq1_write_try, i_rxq0_write_try} = wtry;
	assign {i_txevent_size_zero, i_rxq1_size_zero, i_rxq0_size_zero} = szero;

	always #50 i_clk = ~i_clk;

	cqef_top dut_u (.*);

	// ********
	// Access tasks
	// ********
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr_en <= 1'b1;
		i_addr <= a;
		i_wr_data <= d;
		@(posedge i_clk);
		i_wr_en <= 1'b0;
		#1;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		i_rd_en <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd_en <= 1'b0;
		#1 chk(o_rd_data, exp);
	endtask
	task automatic pulse(input int b);
		@(posedge i_clk);
		ev[b] <= 1'b1;
		@(posedge i_clk);
		ev[b] <= 1'b0;
		#1;
	endtask
	task automatic try_write(input int q, input logic z);
		@(posedge i_clk);
		wtry[q] <= 1'b1;
		szero[q] <= z;
		@(posedge i_clk);
		wtry[q] <= 1'b0;
		#1;
	endtask
	task automatic irq_chk(input logic [1:0] exp);
		@(posedge i_clk);
		#1 chk({30'h0, o_irq_line_second, o_irq_line_first}, {30'h0, exp});
	endtask
	task automatic summarize;
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ********
	// Test sequence
	// ********
	initial begin
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(CQEF_OFS_FLAGS, 32'h0);
		rd(CQEF_OFS_ENABLE, 32'h0);
		rd(CQEF_OFS_LINE_SEL, 32'h0);
		rd(CQEF_OFS_LINE_EN, 32'h0);
		rd(16'h1060, 32'h0);
		$display("test reset_values finished");
		// Every flag alone: set, hold, ignore stray write, clear
		for (int b = 0; b < 16; b++) begin
			pulse(b);
			chk({16'h0000, o_flags}, 32'h1 << b);
			wr(16'h1060, 32'hFFFFFFFF);
			rd(CQEF_OFS_FLAGS, 32'h1 << b);
			wr(CQEF_OFS_FLAGS, 32'h1 << b);
			chk({16'h0000, o_flags}, 32'h0);
		end
		$display("test flag_bits finished");
		// Write attempts count as loss only into a zero size queue
		for (int q = 0; q < 3; q++) begin
			try_write(q, 1'b0);
			chk({16'h0000, o_flags}, 32'h0);
			try_write(q, 1'b1);
			chk({16'h0000, o_flags}, 32'h1 << lost_bit[q]);
			wr(CQEF_OFS_FLAGS, 32'h0000FFFF);
		end
		$display("test zero_size finished");
		wr(CQEF_OFS_ENABLE, 32'h00000201);
		wr(CQEF_OFS_LINE_SEL, 32'h00000200);
		wr(CQEF_OFS_LINE_EN, 32'h00000003);
		rd(CQEF_OFS_ENABLE, 32'h00000201);
		rd(CQEF_OFS_LINE_SEL, 32'h00000200);
		rd(CQEF_OFS_LINE_EN, 32'h00000003);
		pulse(8);
		irq_chk(2'h0);
		pulse(0);
		irq_chk(2'h1);
		pulse(9);
		irq_chk(2'h3);
		wr(CQEF_OFS_LINE_EN, 32'h00000002);
		irq_chk(2'h2);
		wr(CQEF_OFS_FLAGS, 32'h00000200);
		irq_chk(2'h0);
		wr(CQEF_OFS_LINE_EN, 32'h00000001);
		irq_chk(2'h1);
		wr(CQEF_OFS_FLAGS, 32'h0000FFFF);
		irq_chk(2'h0);
		$display("test irq_routing finished");
		// Event and clear in one cycle: the event must survive
		@(posedge i_clk);
		i_wr_en <= 1'b1;
		i_addr <= CQEF_OFS_FLAGS;
		i_wr_data <= 32'h00000001;
		ev[CQEF_B_RXQ0_NEW] <= 1'b1;
		@(posedge i_clk);
		i_wr_en <= 1'b0;
		ev[CQEF_B_RXQ0_NEW] <= 1'b0;
		#1 chk({16'h0000, o_flags}, 32'h00000001);
		wr(CQEF_OFS_FLAGS, 32'h00000001);
		chk({16'h0000, o_flags}, 32'h0);
		$display("test set_wins finished");
		// Second reset in mid-run clears flags and registers
		pulse(5);
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		#1 chk({16'h0000, o_flags}, 32'h0);
		rd(CQEF_OFS_ENABLE, 32'h0);
		rd(CQEF_OFS_LINE_SEL, 32'h0);
		rd(CQEF_OFS_LINE_EN, 32'h0);
		irq_chk(2'h0);
		$display("test mid_reset finished");
		summarize();
	end
endmodule
